//--- tlic_pkg.sv
// package: constants, types and helpers of the two-level interrupt control
package tlic_pkg;

  // ***************************************************************
  // sizes and reset values
  // ***************************************************************
  localparam int unsigned TLIC_NSRC = 16;
  localparam logic [15:0] TLIC_REQ_RST = 16'h0000;
  localparam logic [15:0] TLIC_MASK_RST = 16'hFFFF;
  localparam logic [15:0] TLIC_MODE_RST = 16'h0000;
  localparam logic [15:0] TLIC_PRIO_RST = 16'hFFFF;
  localparam logic [7:0] TLIC_NMST_RST = 8'h00;
  localparam logic [7:0] TLIC_PSW_RST = 8'h02;
  localparam logic [7:0] TLIC_EXT1_RST = 8'h00;
  localparam logic [7:0] TLIC_CONV_RST = 8'h00;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int unsigned TLIC_PSW_ISP_BIT = 1;
  localparam int unsigned TLIC_PSW_IE_BIT = 5;
  localparam int unsigned TLIC_NONMASKABLE_IN_SERVICE_BIT = 0;
  localparam int unsigned TLIC_SLOT4_SEL_LO_BIT = 4;
  localparam int unsigned TLIC_SLOT4_SEL_HI_BIT = 5;
  localparam int unsigned TLIC_CONV_PIN5_BIT = 0;
  localparam logic [3:0] TLIC_SLOT4_IDX = 4'h9;
  localparam logic [3:0] TLIC_SLOT5_IDX = 4'hA;
  localparam logic [1:0] TLIC_SLOT4_TIMER3 = 2'h3;

  // ***************************************************************
  // register access port
  // ***************************************************************
  typedef enum logic [2:0] {
    TLIC_RS_REQ = 3'h0,
    TLIC_RS_MASK = 3'h1,
    TLIC_RS_MODE = 3'h2,
    TLIC_RS_PRIO = 3'h3,
    TLIC_RS_NMST = 3'h4,
    TLIC_RS_PSW = 3'h5,
    TLIC_RS_EXT1 = 3'h6,
    TLIC_RS_CONV = 3'h7
  } tlic_reg_e;

  typedef enum logic [1:0] {
    TLIC_OP_WORD = 2'h0,
    TLIC_OP_LOW = 2'h1,
    TLIC_OP_HIGH = 2'h2,
    TLIC_OP_BIT = 2'h3
  } tlic_op_e;

  typedef struct packed {
    logic req;
    logic we;
    tlic_reg_e sel;
    tlic_op_e op;
    logic [3:0] bitsel;
    logic [15:0] wdata;
  } tlic_acc_s;

  typedef struct packed {
    logic valid;
    logic nmi;
    logic macro;
    logic [3:0] src;
  } tlic_grant_s;

  // ***************************************************************
  // helpers
  // ***************************************************************
  // lowest set bit wins: bit index is the fixed default rank
  function automatic logic [4:0] tlic_first(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = TLIC_NSRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // word, byte or single-bit update of a register image
  function automatic logic [15:0] tlic_apply(input logic [15:0] old, input tlic_acc_s a);
    logic [15:0] r;
    r = old;
    case (a.op)
      TLIC_OP_WORD: r = a.wdata;
      TLIC_OP_LOW: r[7:0] = a.wdata[7:0];
      TLIC_OP_HIGH: r[15:8] = a.wdata[7:0];
      TLIC_OP_BIT: r[a.bitsel] = a.wdata[0];
      default: r = old;
    endcase
    return r;
  endfunction

endpackage

//--- tlic_resolve.sv
// resolver: picks the one request to present to the core
`timescale 1ns/1ps
module tlic_resolve
  import tlic_pkg::*;
(
  input wire logic [15:0] req,
  input wire logic [15:0] mask,
  input wire logic [15:0] mode,
  input wire logic [15:0] prio,
  input wire logic ie,
  input wire logic in_service_priority,
  input wire logic nmi_pend,
  input wire logic nonmaskable_in_service,
  output tlic_pkg::tlic_grant_s grant
);

  logic [15:0] open_req;
  logic [15:0] macro_req;
  logic [15:0] vec_hi;
  logic [15:0] vec_lo;
  logic [4:0] pick_macro;
  logic [4:0] pick_hi;
  logic [4:0] pick_lo;

  // ***************************************************************
  // candidate sets
  // ***************************************************************
  assign open_req = req & ~mask;
  assign macro_req = open_req & mode;
  // global enable gates every vectored request
  assign vec_hi = (ie ? (open_req & ~mode & ~prio) : 16'h0000);
  // low group waits while a high-group service runs
  assign vec_lo = ((ie && in_service_priority) ? (open_req & ~mode & prio) : 16'h0000);

  assign pick_macro = tlic_first(macro_req);
  assign pick_hi = tlic_first(vec_hi);
  assign pick_lo = tlic_first(vec_lo);

  // ***************************************************************
  // precedence: nonmaskable, macro, high group, low group
  // ***************************************************************
  always_comb
  begin
    grant = '0;
    if (nmi_pend && !nonmaskable_in_service)
    begin
      grant.valid = 1'b1;
      grant.nmi = 1'b1;
    end
    else if (pick_macro[4])
    begin
      grant.valid = 1'b1;
      grant.macro = 1'b1;
      grant.src = pick_macro[3:0];
    end
    else if (pick_hi[4])
    begin
      grant.valid = 1'b1;
      grant.src = pick_hi[3:0];
    end
    else if (pick_lo[4])
    begin
      grant.valid = 1'b1;
      grant.src = pick_lo[3:0];
    end
    else
    begin
      grant = '0;
    end
  end

endmodule // tlic_resolve

//--- tlic_ctrl.sv
// top: interrupt request flags, masks, modes, groups, status and grant
//
// Contract
// - a set mask flag refuses its source; clear lets it through
// - one global enable flag gates every maskable vectored request
// - same group pending together: best fixed default rank wins
// - macro service requests ignore group settings and global enable
// - shared slots pass only the selected source
// - two selection bits in external mode one pick pin 4 or timer-3
// - external mode one resets to zero, selecting pin 4
// - converter mode register picks pin 5 or conversion end
// - request, mask, mode, priority: 16-bit, word, byte or bit access
// - nonmaskable status and status word: 8-bit, byte or bit access
// - request flag sets on event, clears on vectored or macro acceptance
// - request flags clear on reset
// - mask flags all set on reset
// - mode flag 0 means vectored, 1 means macro service
// - macro count exhausted clears that source's mode flag
// - mode flags clear on reset
// - priority flag 0 high group, 1 low group
// - vectored acceptance copies the source's priority flag into in-service priority
// - nesting only while enabled; high service admits high group only
// - priority flags all set on reset
// - new nonmaskable request taken only while its status bit is 0
// - status bit sets on nonmaskable acceptance, clears on return
// - vectored acceptance clears enable; nonmaskable also clears in-service priority
// - low group refused while high-group service is active
// - refused nonmaskable stays pending; several collapse into one
// - pending disabled request is taken once enabled
`timescale 1ns/1ps
module tlic_ctrl
  import tlic_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input tlic_pkg::tlic_acc_s acc,
  output logic [15:0] acc_rdata_ff,
  input wire logic [15:0] src_event,
  input wire logic external_pin4_request,
  input wire logic timer3_match_request,
  input wire logic external_pin5_request,
  input wire logic conversion_end_request,
  input wire logic nmi_request,
  input wire logic take,
  input wire logic macro_count_done,
  input wire logic [3:0] macro_done_src,
  input wire logic return_from_interrupt,
  output tlic_pkg::tlic_grant_s grant_ff,
  output logic [7:0] processor_status_word_ff,
  output logic nonmaskable_in_service_ff
);

  // ***************************************************************
  // register images
  // ***************************************************************
  logic [15:0] request_flags_ff;
  logic [15:0] request_masks_ff;
  logic [15:0] service_mode_select_ff;
  logic [15:0] priority_group_select_ff;
  logic [7:0] external_mode_one_ff;
  logic [7:0] converter_mode_register_ff;
  logic nmi_pend_ff;

  logic [15:0] nxt_request_flags;
  logic [15:0] nxt_service_mode_select;
  logic [7:0] nxt_psw;
  logic nxt_nonmaskable_in_service;
  logic nxt_nmi_pend;
  logic [15:0] event_vec;
  logic slot4_request;
  logic slot5_request;
  logic wr;
  logic take_vec;
  logic take_macro;
  logic take_nmi;
  tlic_grant_s nxt_grant;
  // 8-bit registers go through the 16-bit update helper; only the low byte is kept
  logic [15:0] ext1_img;
  logic [15:0] conv_img;
  logic [15:0] psw_img;
  logic [15:0] nmst_img;

  assign ext1_img = tlic_apply({8'h00, external_mode_one_ff}, acc);
  assign conv_img = tlic_apply({8'h00, converter_mode_register_ff}, acc);
  assign psw_img = tlic_apply({8'h00, processor_status_word_ff}, acc);
  assign nmst_img = tlic_apply({15'h0000, nonmaskable_in_service_ff}, acc);

  assign wr = acc.req && acc.we;
  // the core acts on the grant it last saw, one cycle old at most
  assign take_nmi = take && grant_ff.valid && grant_ff.nmi;
  assign take_macro = take && grant_ff.valid && !grant_ff.nmi && grant_ff.macro;
  assign take_vec = take && grant_ff.valid && !grant_ff.nmi && !grant_ff.macro;

  // ***************************************************************
  // shared slot selection
  // ***************************************************************
  always_comb
  begin
    if ({external_mode_one_ff[TLIC_SLOT4_SEL_HI_BIT],
         external_mode_one_ff[TLIC_SLOT4_SEL_LO_BIT]} == TLIC_SLOT4_TIMER3)
    begin
      slot4_request = timer3_match_request;
    end
    else
    begin
      slot4_request = external_pin4_request;
    end
    if (converter_mode_register_ff[TLIC_CONV_PIN5_BIT])
    begin
      slot5_request = external_pin5_request;
    end
    else
    begin
      slot5_request = conversion_end_request;
    end
    event_vec = src_event;
    event_vec[TLIC_SLOT4_IDX] = slot4_request;
    event_vec[TLIC_SLOT5_IDX] = slot5_request;
  end

  // ***************************************************************
  // request flags
  // ***************************************************************
  always_comb
  begin
    nxt_request_flags = request_flags_ff;
    if (wr && acc.sel == TLIC_RS_REQ)
    begin
      nxt_request_flags = tlic_apply(request_flags_ff, acc);
    end
    if (take_vec || take_macro)
    begin
      nxt_request_flags[grant_ff.src] = 1'b0;
    end
    // a new event beats any clear in the same cycle
    nxt_request_flags = nxt_request_flags | event_vec;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      request_flags_ff <= TLIC_REQ_RST;
    end
    else
    begin
      request_flags_ff <= nxt_request_flags;
    end
  end

  // ***************************************************************
  // mask and priority flags
  // ***************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      request_masks_ff <= TLIC_MASK_RST;
    end
    else if (wr && acc.sel == TLIC_RS_MASK)
    begin
      request_masks_ff <= tlic_apply(request_masks_ff, acc);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      priority_group_select_ff <= TLIC_PRIO_RST;
    end
    else if (wr && acc.sel == TLIC_RS_PRIO)
    begin
      priority_group_select_ff <= tlic_apply(priority_group_select_ff, acc);
    end
  end

  // ***************************************************************
  // service mode flags
  // ***************************************************************
  always_comb
  begin
    nxt_service_mode_select = service_mode_select_ff;
    if (wr && acc.sel == TLIC_RS_MODE)
    begin
      nxt_service_mode_select = tlic_apply(service_mode_select_ff, acc);
    end
    // hardware revert outranks a software write in the same cycle
    if (macro_count_done)
    begin
      nxt_service_mode_select[macro_done_src] = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      service_mode_select_ff <= TLIC_MODE_RST;
    end
    else
    begin
      service_mode_select_ff <= nxt_service_mode_select;
    end
  end

  // ***************************************************************
  // source selection registers
  // ***************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      external_mode_one_ff <= TLIC_EXT1_RST;
    end
    else if (wr && acc.sel == TLIC_RS_EXT1)
    begin
      external_mode_one_ff <= ext1_img[7:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      converter_mode_register_ff <= TLIC_CONV_RST;
    end
    else if (wr && acc.sel == TLIC_RS_CONV)
    begin
      converter_mode_register_ff <= conv_img[7:0];
    end
  end

  // ***************************************************************
  // nonmaskable pending and status
  // ***************************************************************
  always_comb
  begin
    nxt_nmi_pend = nmi_pend_ff;
    if (take_nmi)
    begin
      nxt_nmi_pend = 1'b0;
    end
    // one pending bit, so repeats while refused merge into one
    if (nmi_request)
    begin
      nxt_nmi_pend = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      nmi_pend_ff <= 1'b0;
    end
    else
    begin
      nmi_pend_ff <= nxt_nmi_pend;
    end
  end

  always_comb
  begin
    nxt_nonmaskable_in_service = nonmaskable_in_service_ff;
    if (wr && acc.sel == TLIC_RS_NMST)
    begin
      nxt_nonmaskable_in_service = nmst_img[TLIC_NONMASKABLE_IN_SERVICE_BIT];
    end
    if (return_from_interrupt)
    begin
      nxt_nonmaskable_in_service = 1'b0;
    end
    if (take_nmi)
    begin
      nxt_nonmaskable_in_service = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      nonmaskable_in_service_ff <= TLIC_NMST_RST[TLIC_NONMASKABLE_IN_SERVICE_BIT];
    end
    else
    begin
      nonmaskable_in_service_ff <= nxt_nonmaskable_in_service;
    end
  end

  // ***************************************************************
  // status word
  // ***************************************************************
  always_comb
  begin
    nxt_psw = processor_status_word_ff;
    if (wr && acc.sel == TLIC_RS_PSW)
    begin
      nxt_psw = psw_img[7:0];
    end
    if (take_vec)
    begin
      nxt_psw[TLIC_PSW_IE_BIT] = 1'b0;
      nxt_psw[TLIC_PSW_ISP_BIT] = priority_group_select_ff[grant_ff.src];
    end
    if (take_nmi)
    begin
      nxt_psw[TLIC_PSW_IE_BIT] = 1'b0;
      nxt_psw[TLIC_PSW_ISP_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      processor_status_word_ff <= TLIC_PSW_RST;
    end
    else
    begin
      processor_status_word_ff <= nxt_psw;
    end
  end

  // ***************************************************************
  // grant resolution
  // ***************************************************************
  tlic_resolve u_resolve (
    .req(request_flags_ff),
    .mask(request_masks_ff),
    .mode(service_mode_select_ff),
    .prio(priority_group_select_ff),
    .ie(processor_status_word_ff[TLIC_PSW_IE_BIT]),
    .in_service_priority(processor_status_word_ff[TLIC_PSW_ISP_BIT]),
    .nmi_pend(nmi_pend_ff),
    .nonmaskable_in_service(nonmaskable_in_service_ff),
    .grant(nxt_grant)
  );

  // a taken grant is withdrawn at once so it is never taken twice
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      grant_ff <= '0;
    end
    else if (take && grant_ff.valid)
    begin
      grant_ff <= '0;
    end
    else
    begin
      grant_ff <= nxt_grant;
    end
  end

  // ***************************************************************
  // read port
  // ***************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      acc_rdata_ff <= 16'h0000;
    end
    else if (acc.req && !acc.we)
    begin
      case (acc.sel)
        TLIC_RS_REQ: acc_rdata_ff <= request_flags_ff;
        TLIC_RS_MASK: acc_rdata_ff <= request_masks_ff;
        TLIC_RS_MODE: acc_rdata_ff <= service_mode_select_ff;
        TLIC_RS_PRIO: acc_rdata_ff <= priority_group_select_ff;
        TLIC_RS_NMST: acc_rdata_ff <= 16'(nonmaskable_in_service_ff) << TLIC_NONMASKABLE_IN_SERVICE_BIT;
        TLIC_RS_PSW: acc_rdata_ff <= {8'h00, processor_status_word_ff};
        TLIC_RS_EXT1: acc_rdata_ff <= {8'h00, external_mode_one_ff};
        TLIC_RS_CONV: acc_rdata_ff <= {8'h00, converter_mode_register_ff};
        default: acc_rdata_ff <= 16'h0000;
      endcase
    end
  end

endmodule // tlic_ctrl

//--- tlic_ctrl_sva.sv
// checker: port-level assertions of the interrupt control top
`timescale 1ns/1ps
module tlic_ctrl_sva
  import tlic_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input tlic_pkg::tlic_acc_s acc,
  input wire logic [15:0] acc_rdata_ff,
  input wire logic nmi_request,
  input wire logic take,
  input wire logic return_from_interrupt,
  input tlic_pkg::tlic_grant_s grant_ff,
  input wire logic [7:0] processor_status_word_ff,
  input wire logic nonmaskable_in_service_ff
);
  import tlic_pkg::*;
  // ***************
  // helpers
  // ***************
  // acceptance outranks a software write in the same cycle; writes are still excluded
  wire logic wr_psw = acc.req && acc.we && acc.sel == TLIC_RS_PSW;
  wire logic wr_nm = acc.req && acc.we && acc.sel == TLIC_RS_NMST;
  wire logic tk_nmi = take && grant_ff.valid && grant_ff.nmi;
  wire logic tk_vec = take && grant_ff.valid && !grant_ff.nmi && !grant_ff.macro;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_nmi_ev;
    nmi_request && !nonmaskable_in_service_ff && !take;
  endsequence
  sequence s_quiet;
    !nonmaskable_in_service_ff && !take;
  endsequence
  // ***************
  // assertions
  // ***************
  AST_RESET_STATE: assert property (disable iff (1'b0) rst |=>
    processor_status_word_ff == TLIC_PSW_RST && !nonmaskable_in_service_ff && !grant_ff.valid)
    else $error("state not at reset values");
  AST_TAKE_CLEARS: assert property (take && grant_ff.valid |=> !grant_ff.valid)
    else $error("grant not dropped after take");
  AST_VEC_ENABLE_OFF: assert property (tk_vec && !wr_psw |=>
    !processor_status_word_ff[TLIC_PSW_IE_BIT]) else $error("enable kept after vectored take");
  AST_NMI_TAKE: assert property (tk_nmi && !wr_psw && !wr_nm |=> nonmaskable_in_service_ff
    && !processor_status_word_ff[TLIC_PSW_IE_BIT] && !processor_status_word_ff[TLIC_PSW_ISP_BIT])
    else $error("nonmaskable take did not update status");
  AST_NMI_REFUSED: assert property ($past(nonmaskable_in_service_ff) |->
    !(grant_ff.valid && grant_ff.nmi)) else $error("nonmaskable granted while in service");
  AST_VEC_NEEDS_IE: assert property (grant_ff.valid && !grant_ff.nmi && !grant_ff.macro |->
    $past(processor_status_word_ff[TLIC_PSW_IE_BIT])) else $error("vectored grant while disabled");
  AST_NMI_GRANT: assert property (s_nmi_ev ##1 s_quiet |=> grant_ff.valid && grant_ff.nmi)
    else $error("nonmaskable request not granted in two cycles");
  AST_READ_PSW: assert property (acc.req && !acc.we && acc.sel == TLIC_RS_PSW |=>
    acc_rdata_ff == {8'h00, $past(processor_status_word_ff)}) else $error("status word read");
  AST_READ_NMST: assert property (acc.req && !acc.we && acc.sel == TLIC_RS_NMST |=>
    acc_rdata_ff == {15'h0000, $past(nonmaskable_in_service_ff)}) else $error("status read");
  AST_RETURN_CLEARS: assert property (return_from_interrupt && !tk_nmi && !wr_nm |=>
    !nonmaskable_in_service_ff) else $error("return did not clear status bit");
endmodule // tlic_ctrl_sva

bind tlic_ctrl tlic_ctrl_sva chk_u (.clk(clk), .rst(rst), .acc(acc), .acc_rdata_ff(acc_rdata_ff),
  .nmi_request(nmi_request), .take(take), .return_from_interrupt(return_from_interrupt),
  .grant_ff(grant_ff), .processor_status_word_ff(processor_status_word_ff),
  .nonmaskable_in_service_ff(nonmaskable_in_service_ff));

//--- tlic_core_model.sv
// partner: behavioural core that takes grants, ends macro runs and returns
`timescale 1ns/1ps
module tlic_core_model
  import tlic_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input tlic_pkg::tlic_grant_s grant_ff,
  input wire logic [3:0] slow,
  input wire logic ret_en,
  output logic take,
  output logic return_from_interrupt,
  output logic macro_count_done,
  output logic [3:0] macro_done_src
);
  import tlic_pkg::*;
  logic [3:0] wait_ff;
  logic busy_ff;
  // every macro run is treated as its last, so each macro take ends it
  always_ff @(posedge clk)
  begin
    take <= 1'b0;
    macro_count_done <= 1'b0;
    return_from_interrupt <= 1'b0;
    wait_ff <= grant_ff.valid && !take ? wait_ff + 4'h1 : 4'h0;
    if (rst)
    begin
      busy_ff <= 1'b0;
      macro_done_src <= 4'h0;
    end
    else if (grant_ff.valid && !take && wait_ff >= slow)
    begin
      take <= 1'b1;
      wait_ff <= 4'h0;
      macro_count_done <= grant_ff.macro;
      macro_done_src <= grant_ff.src;
      busy_ff <= busy_ff | grant_ff.nmi;
    end
    // return only between grants, so it never meets a take
    else if (busy_ff && ret_en && !grant_ff.valid && !take)
    begin
      return_from_interrupt <= 1'b1;
      busy_ff <= 1'b0;
    end
  end
endmodule // tlic_core_model

//--- tb_top.sv
// testbench: directed and random checks of the interrupt control top
`timescale 1ns/1ps
module tb_top;
  import tlic_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  tlic_acc_s acc = '0;
  logic [15:0] src_event = 16'h0000;
  logic [3:0] pins = 4'h0;
  logic nmi_request = 1'b0;
  logic [3:0] slow = 4'h0;
  logic ret_en = 1'b0;
  logic [15:0] acc_rdata_ff;
  logic take;
  logic return_from_interrupt;
  logic macro_count_done;
  logic [3:0] macro_done_src;
  tlic_grant_s grant_ff;
  logic [7:0] processor_status_word_ff;
  logic nonmaskable_in_service_ff;
  logic [15:0] lfsr = 16'h4C80;
  logic [15:0] pr;
  logic [15:0] ev;
  logic [15:0] img [4] = '{16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF};
  logic [15:0] rst_tab [8] = '{16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000, 16'h0002,
    16'h0000, 16'h0000};
  int miscompares = 0;
  int cmp_count = 0;
  always #2 clk = ~clk;
  tlic_ctrl dut_u (.clk(clk), .rst(rst), .acc(acc), .acc_rdata_ff(acc_rdata_ff),
    .src_event(src_event), .external_pin4_request(pins[0]), .timer3_match_request(pins[1]),
    .external_pin5_request(pins[2]), .conversion_end_request(pins[3]),
    .nmi_request(nmi_request), .take(take), .macro_count_done(macro_count_done),
    .macro_done_src(macro_done_src), .return_from_interrupt(return_from_interrupt),
    .grant_ff(grant_ff), .processor_status_word_ff(processor_status_word_ff),
    .nonmaskable_in_service_ff(nonmaskable_in_service_ff));
  tlic_core_model core_u (.clk(clk), .rst(rst), .grant_ff(grant_ff), .slow(slow),
    .ret_en(ret_en), .take(take), .return_from_interrupt(return_from_interrupt),
    .macro_count_done(macro_count_done), .macro_done_src(macro_done_src));
  // ***************
  // helpers
  // ***************
  function automatic logic [15:0] step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [15:0] merge(input logic [15:0] o, input int op,
    input logic [3:0] b, input logic [15:0] d);
    logic [15:0] r;
    r = o;
    if (op == 0) r = d;
    if (op == 1) r[7:0] = d[7:0];
    if (op == 2) r[15:8] = d[7:0];
    if (op == 3) r[b] = d[0];
    return r;
  endfunction
  // high group first, then lowest index inside the group
  function automatic logic [3:0] winner(input logic [15:0] p, input logic [15:0] g);
    logic [15:0] h;
    h = (p & ~g) != 16'h0000 ? p & ~g : p;
    winner = 4'h0;
    for (int i = 15; i >= 0; i--)
      if (h[i]) winner = 4'(i);
  endfunction
  task automatic close_out();
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic put(input logic we, input tlic_reg_e s, input tlic_op_e op,
    input logic [3:0] b, input logic [15:0] d);
    acc = '{1'b1, we, s, op, b, d};
    tick(1);
    acc.req = 1'b0;
    tick(1);
  endtask
  task automatic rd(input tlic_reg_e s, input logic [15:0] exp, input string what);
    put(1'b0, s, TLIC_OP_WORD, 4'h0, 16'h0000);
    chk(what, exp, acc_rdata_ff);
  endtask
  task automatic fire(input logic [15:0] e, input logic [3:0] p, input logic n);
    src_event = e;
    pins = p;
    nmi_request = n;
    tick(1);
    src_event = 16'h0000;
    pins = 4'h0;
    nmi_request = 1'b0;
    tick(1);
  endtask
  task automatic watch(input int n, input int exp, input string what);
    int c;
    c = 0;
    repeat (n)
    begin
      c += (take === 1'b1);
      tick(1);
    end
    chk(what, 16'(exp), 16'(c));
  endtask
  task automatic serve(input logic [6:0] exp, input logic [6:0] care, input string what);
    int n;
    n = 0;
    while (take !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    if (n == 40)
    begin
      miscompares++;
      close_out();
    end
    else
    begin
      chk(what, {9'h000, exp & care}, {9'h000, grant_ff & care});
      tick(1);
    end
  endtask
  // ***************
  // main sequence
  // ***************
  initial
  begin
    tick(12);
    rst = 1'b0;
    tick(1);
    for (int i = 0; i < 8; i++)
      rd(tlic_reg_e'(i), rst_tab[i], "reset value");
    for (int k = 0; k < 8; k++)
    begin
      lfsr = step(lfsr);
      img[k % 2 * 3] = merge(img[k % 2 * 3], k / 2, lfsr[11:8], lfsr);
      put(1'b1, tlic_reg_e'(k % 2 * 3), tlic_op_e'(k / 2), lfsr[11:8], lfsr);
      rd(tlic_reg_e'(k % 2 * 3), img[k % 2 * 3], "word byte bit access");
    end
    put(1'b1, TLIC_RS_EXT1, TLIC_OP_HIGH, 4'h0, 16'h00FF);
    rd(TLIC_RS_EXT1, 16'h0000, "upper byte of 8-bit register");
    put(1'b1, TLIC_RS_REQ, TLIC_OP_WORD, 4'h0, 16'h0000);
    for (int k = 0; k < 8; k++)
    begin
      put(1'b1, TLIC_RS_EXT1, TLIC_OP_WORD, 4'h0, k < 4 ? 16'h0000 : 16'h0030);
      put(1'b1, TLIC_RS_CONV, TLIC_OP_WORD, 4'h0, k < 4 ? 16'h0000 : 16'h0001);
      fire(16'h0000, 4'(1 << (k % 4)), 1'b0);
      rd(TLIC_RS_REQ, ((k % 4 == 0 || k % 4 == 3) ^ (k >= 4)) ? (k % 4 < 2 ? 16'h0200 :
        16'h0400) : 16'h0000, "shared slot flag");
      put(1'b1, TLIC_RS_REQ, TLIC_OP_WORD, 4'h0, 16'h0000);
    end
    put(1'b1, TLIC_RS_MASK, TLIC_OP_WORD, 4'h0, 16'h0000);
    for (int k = 0; k < 6; k++)
    begin
      lfsr = step(lfsr);
      pr = k == 0 ? 16'hFFFF : k == 1 ? 16'hFF7F : lfsr;
      ev = k == 0 ? 16'h0024 : k == 1 ? 16'h0088 : (step(lfsr) & 16'hF9FF) | 16'h4000;
      slow = lfsr[3:0] & 4'h3;
      put(1'b1, TLIC_RS_PSW, TLIC_OP_WORD, 4'h0, 16'h0002);
      put(1'b1, TLIC_RS_PRIO, TLIC_OP_WORD, 4'h0, pr);
      fire(ev, 4'h0, 1'b0);
      watch(6, 0, "grant while disabled");
      put(1'b1, TLIC_RS_PSW, TLIC_OP_WORD, 4'h0, 16'h0022);
      serve({3'b100, winner(ev, pr)}, 7'h7F, "vectored winner");
      rd(TLIC_RS_PSW, {14'h0000, pr[winner(ev, pr)], 1'b0}, "status after take");
      put(1'b1, TLIC_RS_REQ, TLIC_OP_WORD, 4'h0, 16'h0000);
    end
    slow = 4'h0;
    put(1'b1, TLIC_RS_MASK, TLIC_OP_BIT, 4'h6, 16'h0001);
    put(1'b1, TLIC_RS_PRIO, TLIC_OP_WORD, 4'h0, 16'hFFBF);
    put(1'b1, TLIC_RS_PSW, TLIC_OP_WORD, 4'h0, 16'h0020);
    fire(16'h0040, 4'h0, 1'b0);
    watch(8, 0, "masked source");
    put(1'b1, TLIC_RS_PRIO, TLIC_OP_BIT, 4'h6, 16'h0001);
    put(1'b1, TLIC_RS_MASK, TLIC_OP_BIT, 4'h6, 16'h0000);
    watch(8, 0, "low group in high service");
    put(1'b1, TLIC_RS_PRIO, TLIC_OP_BIT, 4'h6, 16'h0000);
    serve(7'h46, 7'h7F, "pending source once enabled");
    put(1'b1, TLIC_RS_PSW, TLIC_OP_WORD, 4'h0, 16'h0002);
    put(1'b1, TLIC_RS_MODE, TLIC_OP_BIT, 4'h4, 16'h0001);
    fire(16'h0010, 4'h0, 1'b0);
    serve(7'h54, 7'h7F, "macro grant with enable off");
    rd(TLIC_RS_MODE, 16'h0000, "mode after last macro");
    rd(TLIC_RS_REQ, 16'h0000, "flag after macro");
    put(1'b1, TLIC_RS_PSW, TLIC_OP_WORD, 4'h0, 16'h0022);
    fire(16'h0000, 4'h0, 1'b1);
    serve(7'h60, 7'h70, "nonmaskable grant");
    rd(TLIC_RS_PSW, 16'h0000, "status after nonmaskable take");
    rd(TLIC_RS_NMST, 16'h0001, "nonmaskable status");
    fire(16'h0000, 4'h0, 1'b1);
    fire(16'h0000, 4'h0, 1'b1);
    watch(10, 0, "nonmaskable while in service");
    ret_en = 1'b1;
    watch(30, 1, "collapsed nonmaskable takes");
    ret_en = 1'b0;
    close_out();
  end
endmodule // tb_top
